// ---- rtl/ssr_sram_axi.sv ----
/*
 * secure on-chip sram behind an axi slave port, one transaction at a time.
 * assumes the interconnect routes only the cpu cluster, bus dma controller
 * and cipher engine here, and uses no lock or exclusive semantics.
 */
`timescale 1ns/10ps
`default_nettype none

// Function
// - 36 KB contiguous storage behind slave port
// - axi slave accepting reads and writes
// - data bus is 64 bits wide
// - bridge turns axi beats into array cycles
// - secure and non-secure accesses treated per region
// - secure region is whole 4 KB pages
// - software sets secure boundary via configuration
// - cache attributes ignored for every access
// - no protection function beyond region check
// - without remap answer only low window
// - config bit 10 enables remap, low stays
// - remap adds high alias window
module ssr_sram_axi
    import ssr_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic [31:0]           secure_config_reg0_i,
    input  wire logic [3:0]            secure_pages_i,
    input  wire logic [SSR_ID_W-1:0]   awid_i,
    input  wire logic [SSR_ADDR_W-1:0] awaddr_i,
    input  wire logic [7:0]            awlen_i,
    input  wire logic [2:0]            awsize_i,
    input  wire logic [1:0]            awburst_i,
    input  wire logic [2:0]            awprot_i,
    input  wire logic [3:0]            awcache_i,
    input  wire logic                  awlock_i,
    input  wire logic                  awvalid_i,
    output var  logic                  awready_o,
    input  wire logic [SSR_DATA_W-1:0] wdata_i,
    input  wire logic [7:0]            wstrb_i,
    input  wire logic                  wlast_i,
    input  wire logic                  wvalid_i,
    output var  logic                  wready_o,
    output var  logic [SSR_ID_W-1:0]   bid_o,
    output var  logic [1:0]            bresp_o,
    output var  logic                  bvalid_o,
    input  wire logic                  bready_i,
    input  wire logic [SSR_ID_W-1:0]   arid_i,
    input  wire logic [SSR_ADDR_W-1:0] araddr_i,
    input  wire logic [7:0]            arlen_i,
    input  wire logic [2:0]            arsize_i,
    input  wire logic [1:0]            arburst_i,
    input  wire logic [2:0]            arprot_i,
    input  wire logic [3:0]            arcache_i,
    input  wire logic                  arlock_i,
    input  wire logic                  arvalid_i,
    output var  logic                  arready_o,
    output var  logic [SSR_ID_W-1:0]   rid_o,
    output var  logic [SSR_DATA_W-1:0] rdata_o,
    output var  logic [1:0]            rresp_o,
    output var  logic                  rlast_o,
    output var  logic                  rvalid_o,
    input  wire logic                  rready_i
);

    // address decode: 0 = miss, 1 = hit in the low window or, with remap, the high window
    function automatic logic hit_f(input logic [31:0] a, input logic remap);
        hit_f = ((a >= SSR_BASE_LOW) && (a <= SSR_LAST_LOW))
             || (remap && (a >= SSR_BASE_HIGH) && (a <= SSR_LAST_HIGH));
    endfunction

    // both windows alias the same storage through the low 16 bits
    function automatic logic [15:0] off_f(input logic [31:0] a);
        off_f = a[15:0];
    endfunction

    // secure check: whole pages below the boundary are secure
    function automatic logic sec_f(input logic [15:0] off, input logic [3:0] pages);
        logic [3:0] pg;
        pg    = off[15:12];
        sec_f = (pg < pages);
    endfunction

    // next beat address for incr and wrap; fixed stays put
    function automatic logic [31:0] next_f(input logic [31:0] a, input logic [2:0] sz,
                                           input logic [1:0] bt, input logic [7:0] len);
        logic [31:0] step;
        logic [31:0] span;
        logic [31:0] nxt;
        step = 32'h1 << sz;
        span = step * ({24'h0, len} + 32'h1);
        nxt  = a + step;
        if (bt == SSR_BURST_FIXED) begin
            next_f = a;
        end else if (bt == SSR_BURST_WRAP) begin
            next_f = (a & ~(span - 32'h1)) | (nxt & (span - 32'h1));
        end else begin
            next_f = nxt;
        end
    endfunction

    // storage array, never reset
    logic [SSR_DATA_W-1:0] mem_q [SSR_WORDS];

    ssr_state_t            state_q;
    logic [31:0]           addr_q;
    logic [7:0]            len_q;
    logic [7:0]            cnt_q;
    logic [2:0]            size_q;
    logic [1:0]            burst_q;
    logic                  ns_q;
    logic                  err_q;
    logic [1:0]            werr_q;
    logic [3:0]            pages_q;
    logic                  remap_q;

    // cache, lock and most prot bits are unused by design
    logic                  unused_w;
    assign unused_w = ^{awcache_i, arcache_i, awlock_i, arlock_i,
                        awprot_i[2], awprot_i[0], arprot_i[2], arprot_i[0], wlast_i,
                        secure_config_reg0_i[31:11], secure_config_reg0_i[9:0]};

    // current beat decode
    logic                  beat_hit;
    logic [15:0]           beat_off;
    logic                  beat_sec;
    logic [SSR_IDX_W-1:0]  beat_idx;
    assign beat_hit = hit_f(addr_q, remap_q);
    assign beat_off = off_f(addr_q);
    assign beat_sec = sec_f(beat_off, pages_q);
    assign beat_idx = beat_off[15:3];

    logic                  beat_bad;
    logic [1:0]            beat_resp;
    assign beat_bad  = !beat_hit || (ns_q && beat_sec);
    assign beat_resp = !beat_hit ? SSR_RESP_DECERR :
                       (ns_q && beat_sec) ? SSR_RESP_SLVERR : SSR_RESP_OKAY;

    // configuration capture: boundary clamps to the whole memory
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pages_q <= 4'h0;
            remap_q <= 1'b0;
        end else begin
            pages_q <= (secure_pages_i > 4'(SSR_PAGES)) ? 4'(SSR_PAGES) : secure_pages_i;
            remap_q <= secure_config_reg0_i[SSR_REMAP_BIT];
        end
    end

    // transaction sequencer; one address channel offered at a time when idle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q   <= SSR_IDLE;
            addr_q    <= 32'h0;
            len_q     <= 8'h0;
            cnt_q     <= 8'h0;
            size_q    <= 3'h0;
            burst_q   <= 2'h0;
            ns_q      <= 1'b0;
            err_q     <= 1'b0;
            werr_q    <= SSR_RESP_OKAY;
            awready_o <= 1'b1;
            arready_o <= 1'b0;
            wready_o  <= 1'b0;
            bvalid_o  <= 1'b0;
            bresp_o   <= SSR_RESP_OKAY;
            bid_o     <= '0;
            rvalid_o  <= 1'b0;
            rdata_o   <= '0;
            rresp_o   <= SSR_RESP_OKAY;
            rlast_o   <= 1'b0;
            rid_o     <= '0;
        end else begin
            case (state_q)
                SSR_IDLE: begin
                    if (awready_o && awvalid_i) begin
                        addr_q    <= awaddr_i;
                        len_q     <= awlen_i;
                        cnt_q     <= 8'h0;
                        size_q    <= awsize_i;
                        burst_q   <= awburst_i;
                        ns_q      <= awprot_i[1];
                        werr_q    <= SSR_RESP_OKAY;
                        bid_o     <= awid_i;
                        awready_o <= 1'b0;
                        arready_o <= 1'b0;
                        wready_o  <= 1'b1;
                        state_q   <= SSR_WDATA;
                    end else if (arready_o && arvalid_i) begin
                        addr_q    <= araddr_i;
                        len_q     <= arlen_i;
                        cnt_q     <= 8'h0;
                        size_q    <= arsize_i;
                        burst_q   <= arburst_i;
                        ns_q      <= arprot_i[1];
                        rid_o     <= arid_i;
                        awready_o <= 1'b0;
                        arready_o <= 1'b0;
                        err_q     <= 1'b1;
                        state_q   <= SSR_RDATA;
                    end else if (awready_o && arvalid_i) begin
                        awready_o <= 1'b0;                       // offer moves to reads
                        arready_o <= 1'b1;
                    end else if (arready_o && awvalid_i) begin
                        awready_o <= 1'b1;                       // offer moves to writes
                        arready_o <= 1'b0;
                    end
                end
                SSR_WDATA: begin
                    if (wvalid_i) begin
                        if (beat_bad && (beat_resp > werr_q)) begin
                            werr_q <= beat_resp;
                        end
                        addr_q <= next_f(addr_q, size_q, burst_q, len_q);
                        cnt_q  <= cnt_q + 8'h1;
                        if (cnt_q == len_q) begin
                            wready_o <= 1'b0;
                            bvalid_o <= 1'b1;
                            bresp_o  <= (beat_bad && (beat_resp > werr_q)) ? beat_resp : werr_q;
                            state_q  <= SSR_WRESP;
                        end
                    end
                end
                SSR_WRESP: begin
                    if (bready_i) begin
                        bvalid_o  <= 1'b0;
                        awready_o <= 1'b1;
                        arready_o <= 1'b0;
                        state_q   <= SSR_IDLE;
                    end
                end
                SSR_RDATA: begin
                    // err_q marks that the output slot is free for a new beat
                    if (err_q || (rvalid_o && rready_i)) begin
                        if (!err_q && rlast_o) begin
                            rvalid_o  <= 1'b0;
                            rlast_o   <= 1'b0;
                            awready_o <= 1'b1;
                            arready_o <= 1'b0;
                            state_q   <= SSR_IDLE;
                        end else begin
                            rvalid_o <= 1'b1;
                            rdata_o  <= beat_bad ? '0 : mem_q[beat_idx];
                            rresp_o  <= beat_resp;
                            rlast_o  <= (cnt_q == len_q);
                            addr_q   <= next_f(addr_q, size_q, burst_q, len_q);
                            cnt_q    <= cnt_q + 8'h1;
                            err_q    <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= SSR_IDLE;
                end
            endcase
        end
    end

    // array write port with byte strobes; blocked beats leave memory alone
    always_ff @(posedge clk_i) begin
        if ((state_q == SSR_WDATA) && wvalid_i && !beat_bad) begin
            for (int b = 0; b < 8; b++) begin
                if (wstrb_i[b]) begin
                    mem_q[beat_idx][b*8 +: 8] <= wdata_i[b*8 +: 8];
                end
            end
        end
    end

    // a non-secure read of a secure page returns zero with an error
    AST_NS_READ_BLOCKED: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == SSR_RDATA) && (err_q || (rvalid_o && rready_i)) && !(rlast_o && !err_q)
        && beat_hit && ns_q && beat_sec
        |=> rvalid_o && (rdata_o == '0) && (rresp_o == SSR_RESP_SLVERR))
        else $error("non-secure read of secure page not blocked");

    // high window misses while remap is off
    AST_HIGH_NEEDS_REMAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == SSR_RDATA) && err_q && !remap_q && (addr_q >= SSR_BASE_HIGH)
        |=> rvalid_o && (rresp_o == SSR_RESP_DECERR))
        else $error("high window answered without remap");

    // low window always decodes
    AST_LOW_ALWAYS_HITS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == SSR_RDATA) && err_q && !ns_q
        && (addr_q >= SSR_BASE_LOW) && (addr_q <= SSR_LAST_LOW)
        |=> rresp_o == SSR_RESP_OKAY)
        else $error("low window refused");

    // write response follows the last data beat by one cycle
    AST_WRITE_RESP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == SSR_WDATA) && wvalid_i && (cnt_q == len_q) |=> bvalid_o && !wready_o)
        else $error("write response missing after last beat");

    // bvalid holds until accepted
    AST_BVALID_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped");

    // read beat holds while stalled
    AST_RVALID_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rlast_o))
        else $error("read beat changed under stall");

    // secure boundary never exceeds the whole memory
    AST_PAGES_CLAMP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pages_q <= 4'(SSR_PAGES))
        else $error("secure boundary beyond memory");

    // remap follows configuration bit one cycle later
    AST_REMAP_TRACK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ##1 remap_q == $past(secure_config_reg0_i[SSR_REMAP_BIT]))
        else $error("remap bit not tracked");

    // no new address is taken while busy
    AST_ONE_AT_A_TIME: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q != SSR_IDLE) |-> !awready_o && !arready_o)
        else $error("address accepted while busy");

    // at most one address channel is offered, so no handshake is lost
    AST_ONE_OFFER: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(awready_o && arready_o))
        else $error("both address channels offered");

    COV_WRITE:    cover property (@(posedge clk_i) bvalid_o && bready_i && bresp_o == SSR_RESP_OKAY);
    COV_READ:     cover property (@(posedge clk_i) rvalid_o && rready_i && rlast_o);
    COV_SEC_ERR:  cover property (@(posedge clk_i) rvalid_o && rresp_o == SSR_RESP_SLVERR);
    COV_HIGH_HIT: cover property (@(posedge clk_i) (state_q == SSR_RDATA) && remap_q
                                  && (addr_q >= SSR_BASE_HIGH) && beat_hit);

endmodule

`default_nettype wire

// ---- rtl/ssr_pkg.sv ----
/*
 * package for the secure on-chip sram axi slave: address windows,
 * sizes, field positions and response codes.
 * assumes a 64-bit axi interconnect with 32-bit addresses.
 */
package ssr_pkg;
    localparam int          SSR_DATA_W      = 64;
    localparam int          SSR_ADDR_W      = 32;
    localparam int          SSR_ID_W        = 4;
    localparam int          SSR_BYTES       = 36 * 1024;
    localparam int          SSR_WORDS       = SSR_BYTES / 8;
    localparam int          SSR_IDX_W       = 13;
    localparam int          SSR_PAGE_SHIFT  = 12;
    localparam int          SSR_PAGES       = 9;
    localparam int          SSR_REMAP_BIT   = 10;
    localparam logic [31:0] SSR_BASE_LOW    = 32'hff09_0000;
    localparam logic [31:0] SSR_LAST_LOW    = 32'hff09_8fff;
    localparam logic [31:0] SSR_BASE_HIGH   = 32'hffff_0000;
    localparam logic [31:0] SSR_LAST_HIGH   = 32'hffff_8fff;
    localparam logic [1:0]  SSR_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SSR_RESP_SLVERR = 2'h2;
    localparam logic [1:0]  SSR_RESP_DECERR = 2'h3;
    localparam logic [1:0]  SSR_BURST_FIXED = 2'h0;
    localparam logic [1:0]  SSR_BURST_WRAP  = 2'h2;

    typedef enum logic [1:0] {
        SSR_IDLE  = 2'b00,
        SSR_WDATA = 2'b01,
        SSR_WRESP = 2'b10,
        SSR_RDATA = 2'b11
    } ssr_state_t;
endpackage

// ---- bench/ssr_axi_master.sv ----
/*
 * partner model: one axi master of the system interconnect, ids from address bits,
 * one transaction at a time, driven through its wr and rd tasks.
 * assumes the slave ports keep their declared names, so .* connects it.
 */
`timescale 1ns/10ps
`default_nettype none

module ssr_axi_master
    import ssr_pkg::*;
(
    input  wire logic clk_i, awready_o, wready_o, bvalid_o, arready_o, rlast_o, rvalid_o,
    input  wire logic [1:0]            bresp_o, rresp_o,
    input  wire logic [SSR_ID_W-1:0]   bid_o, rid_o,
    input  wire logic [SSR_DATA_W-1:0] rdata_o,
    output var  logic awvalid_i, awlock_i, wlast_i, wvalid_i, bready_i, arvalid_i, arlock_i,
    output var  logic                  rready_i,
    output var  logic [SSR_ID_W-1:0]   awid_i, arid_i,
    output var  logic [SSR_ADDR_W-1:0] awaddr_i, araddr_i,
    output var  logic [7:0]            awlen_i, arlen_i, wstrb_i,
    output var  logic [2:0]            awsize_i, awprot_i, arsize_i, arprot_i,
    output var  logic [1:0]            awburst_i, arburst_i,
    output var  logic [3:0]            awcache_i, arcache_i,
    output var  logic [SSR_DATA_W-1:0] wdata_i
);
    logic [SSR_DATA_W-1:0] rd_q [0:7];
    logic [1:0]            resp_q;
    logic [SSR_ID_W-1:0]   id_q;
    logic                  last_q;

    // idle master at time zero: full 64-bit incr beats, no exclusive use
    initial begin
        {awvalid_i, awlock_i, wlast_i, wvalid_i, bready_i} = '0;
        {arvalid_i, arlock_i, rready_i, awlen_i, arlen_i} = '0;
        {awid_i, arid_i, awaddr_i, araddr_i, wdata_i} = '0;
        {awprot_i, arprot_i, awcache_i, arcache_i} = '0;
        {awsize_i, arsize_i, awburst_i, arburst_i} = {3'h3, 3'h3, 2'h1, 2'h1};
        wstrb_i = 8'hff;
        resp_q  = 2'h0;
    end

    // write burst; cache, lock and spare prot bits vary with the address
    task automatic wr(input logic [31:0] a, input logic [7:0] len, input logic ns,
                      input logic [63:0] d);
        int i;
        @(posedge clk_i);
        awaddr_i  <= a;
        awid_i    <= a[6:3];
        awlen_i   <= len;
        awprot_i  <= {a[5], ns, a[4]};
        awcache_i <= a[6:3];
        awlock_i  <= a[3];
        awvalid_i <= 1'b1;
        do @(posedge clk_i); while (awready_o !== 1'b1);
        awvalid_i <= 1'b0;
        awaddr_i  <= ~a;
        for (i = 0; i <= len; i++) begin
            wdata_i  <= d + i;
            wlast_i  <= (i == len);
            wvalid_i <= 1'b1;
            do @(posedge clk_i); while (wready_o !== 1'b1);
        end
        wvalid_i <= 1'b0;
        wdata_i  <= ~wdata_i;
        do @(posedge clk_i); while (bvalid_o !== 1'b1);
        bready_i <= 1'b1; // response stalled one cycle, so it must hold
        @(posedge clk_i);
        resp_q = bresp_o;
        id_q   = bid_o;
        bready_i <= 1'b0;
    endtask

    // read burst; beats land in rd_q, worst response in resp_q
    task automatic rd(input logic [31:0] a, input logic [7:0] len, input logic ns);
        int i;
        @(posedge clk_i);
        araddr_i  <= a;
        arid_i    <= a[7:4];
        arlen_i   <= len;
        arprot_i  <= {a[4], ns, a[5]};
        arcache_i <= ~a[6:3];
        arlock_i  <= a[4];
        arvalid_i <= 1'b1;
        do @(posedge clk_i); while (arready_o !== 1'b1);
        arvalid_i <= 1'b0;
        araddr_i  <= ~a;
        resp_q = 2'h0;
        for (i = 0; i <= len; i++) begin
            do @(posedge clk_i); while (rvalid_o !== 1'b1);
            rready_i <= 1'b1; // each beat stalled once, so it must hold
            @(posedge clk_i);
            rd_q[i] = rdata_o;
            last_q  = rlast_o;
            id_q    = rid_o;
            if (rresp_o > resp_q)
                resp_q = rresp_o;
            rready_i <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/secure_onchip_sram_axi_slave_tb.sv ----
/*
 * self-checking bench for the secure sram slave: windows, remap, secure
 * pages, bursts and reset retention, traffic through one master model.
 * assumes the design and the master model share the slave port names.
 */
`timescale 1ns/10ps
`default_nettype none

module secure_onchip_sram_axi_slave_tb;
    import ssr_pkg::*;
    localparam logic [31:0] LO = SSR_BASE_LOW;
    localparam logic [31:0] HI = SSR_BASE_HIGH;
    localparam logic [63:0] PA = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] PB = 64'ha5a5_0000_0000_0010;
    logic clk_i, reset_n_i, awready_o, wready_o, bvalid_o, arready_o, rlast_o, rvalid_o;
    logic awvalid_i, awlock_i, wlast_i, wvalid_i, bready_i, arvalid_i, arlock_i, rready_i;
    logic [1:0]  bresp_o, rresp_o, awburst_i, arburst_i;
    logic [3:0]  bid_o, rid_o, awid_i, arid_i, awcache_i, arcache_i, secure_pages_i;
    logic [7:0]  awlen_i, arlen_i, wstrb_i;
    logic [2:0]  awsize_i, awprot_i, arsize_i, arprot_i;
    logic [31:0] awaddr_i, araddr_i, secure_config_reg0_i;
    logic [63:0] wdata_i, rdata_o;
    int          fail_count;
    int          cmp_count;

    ssr_sram_axi   dut (.*);
    ssr_axi_master m   (.*);

    // free-running 50 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk64(input string n, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk4(input string n, input logic [3:0] e, input logic [3:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // single-beat read judged on data and response
    task automatic rdchk(input logic [31:0] a, input logic ns, input logic [63:0] d,
                         input logic [1:0] r);
        m.rd(a, 8'h0, ns);
        chk64("rdata", d, m.rd_q[0]);
        chk2("rresp", r, m.resp_q);
        chk4("rid", a[7:4], m.id_q);
    endtask

    task automatic wrchk(input logic [31:0] a, input logic ns, input logic [63:0] d,
                         input logic [1:0] r);
        m.wr(a, 8'h0, ns, d);
        chk2("bresp", r, m.resp_q);
        chk4("bid", a[6:3], m.id_q);
    endtask

    task automatic t_basic();
        wrchk(LO, 1'b0, PA, SSR_RESP_OKAY);
        rdchk(LO, 1'b0, PA, SSR_RESP_OKAY);
        wrchk(LO + 32'h8ff8, 1'b0, ~PA, SSR_RESP_OKAY);
        rdchk(LO + 32'h8ff8, 1'b0, ~PA, SSR_RESP_OKAY);
        $display("test basic done");
    endtask

    task automatic t_burst();
        int i;
        m.wr(LO + 32'h100, 8'h3, 1'b0, PB);
        chk2("bresp", SSR_RESP_OKAY, m.resp_q);
        m.rd(LO + 32'h100, 8'h3, 1'b0);
        chk2("rlast", 2'h1, {1'b0, m.last_q});
        for (i = 0; i < 4; i++)
            chk64("burst", PB + i, m.rd_q[i]);
        chk2("rresp", SSR_RESP_OKAY, m.resp_q);
        $display("test burst done");
    endtask

    task automatic t_window();
        rdchk(LO + 32'h9000, 1'b0, 64'h0, SSR_RESP_DECERR);
        wrchk(LO + 32'h9000, 1'b0, PA, SSR_RESP_DECERR);
        secure_config_reg0_i <= ~(32'h1 << SSR_REMAP_BIT);
        repeat (2) @(posedge clk_i);
        rdchk(HI, 1'b0, 64'h0, SSR_RESP_DECERR);
        secure_config_reg0_i <= 32'h1 << SSR_REMAP_BIT;
        repeat (2) @(posedge clk_i);
        rdchk(HI, 1'b0, PA, SSR_RESP_OKAY);
        wrchk(HI + 32'h8ff8, 1'b0, PB, SSR_RESP_OKAY);
        rdchk(LO + 32'h8ff8, 1'b0, PB, SSR_RESP_OKAY);
        rdchk(HI + 32'h9000, 1'b0, 64'h0, SSR_RESP_DECERR);
        secure_config_reg0_i <= 32'h0;
        repeat (2) @(posedge clk_i);
        $display("test window done");
    endtask

    task automatic t_secure();
        secure_pages_i <= 4'h2;
        repeat (2) @(posedge clk_i);
        wrchk(LO + 32'h1ff8, 1'b0, PA, SSR_RESP_OKAY);
        wrchk(LO + 32'h1ff8, 1'b1, PB, SSR_RESP_SLVERR);
        rdchk(LO + 32'h1ff8, 1'b0, PA, SSR_RESP_OKAY);
        rdchk(LO + 32'h1ff8, 1'b1, 64'h0, SSR_RESP_SLVERR);
        wrchk(LO + 32'h2000, 1'b1, PB, SSR_RESP_OKAY);
        rdchk(LO + 32'h2000, 1'b1, PB, SSR_RESP_OKAY);
        secure_pages_i <= 4'h9;
        repeat (2) @(posedge clk_i);
        rdchk(LO + 32'h8ff8, 1'b1, 64'h0, SSR_RESP_SLVERR);
        rdchk(LO + 32'h8ff8, 1'b0, PB, SSR_RESP_OKAY);
        secure_pages_i <= 4'h0;
        repeat (2) @(posedge clk_i);
        rdchk(LO + 32'h1ff8, 1'b1, PA, SSR_RESP_OKAY);
        $display("test secure done");
    endtask

    task automatic t_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rdchk(LO + 32'h108, 1'b0, PB + 1, SSR_RESP_OKAY);
        rdchk(LO, 1'b1, PA, SSR_RESP_OKAY);
        $display("test reset done");
    endtask

    // main sequence: reset for 4 cycles, two idle edges, then the tests
    initial begin
        reset_n_i            = 1'b0;
        secure_config_reg0_i = 32'h0;
        secure_pages_i       = 4'h0;
        fail_count           = 0;
        cmp_count            = 0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_basic();
        t_burst();
        t_window();
        t_secure();
        t_reset();
        give_verdict();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(20 * 5000);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
